// *** dwr_bus_master.sv ***
// dwr_bus_master: behavioural two-wire bus master for the bench.
// assumes sda_i is the resolved wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module dwr_bus_master (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// data moves one clock after scl falls, so no hold race
	task automatic bit_x(input logic b, output logic r);
		wt(1);
		sda_low_o <= ~b;
		wt(3);
		scl_o <= 1'b1;
		wt(4);
		r = sda_i;
		scl_o <= 1'b0;
	endtask
	task automatic start();
		wt(1);
		sda_low_o <= 1'b0;
		wt(2);
		scl_o <= 1'b1;
		wt(4);
		sda_low_o <= 1'b1;
		wt(4);
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		wt(1);
		sda_low_o <= 1'b1;
		wt(3);
		scl_o <= 1'b1;
		wt(4);
		sda_low_o <= 1'b0;
		wt(4);
	endtask
	// msb first; ninth bit carries the master ack when m_ack is set
	task automatic byte_x(input logic [7:0] d, input logic m_ack,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(~m_ack, r);
		ack = ~r;
	endtask
endmodule // dwr_bus_master
`default_nettype wire

// *** dwr_pkg.sv ***
// dwr_pkg: constants, opcodes and state codes for the dual wiper register control.
// assumes one system clock of CLK_MHZ; the serial bus arrives asynchronously on pins.
// Function
// - each pot owns one 6-bit wiper position register selecting its tap.
// - four 6-bit non-volatile stored settings per pot.
// - at power-up the first stored setting is loaded into each wiper register.
// - write guard low blocks stored-setting programming; wiper writes still allowed.
// - write guard high or floating allows every read and write.
// - transfer starts only when address bits match the four strap inputs.
// - 63 series elements per pot, so 64 taps.
// - exactly one tap per pot connected, decoded from the wiper register.
// - master reads and writes wiper and stored registers over the bus.
// - copy commands move values between wiper and stored settings, both ways.
// - a step mode moves the wiper one tap up or down per bit.
// - data line is open drain: pull low or release only.
// - master clocks all bits; device samples and shifts only on that clock.
// - address byte is a four-bit type prefix then straps bit3 down to bit0.
// - instruction byte is opcode, register select, pot select; acked, then data.
// - after stop of a stored write, program and ignore own address until done.
// - guarded stored write: ack address and instruction, nack data, no programming.
package dwr_pkg;
	localparam int CLK_MHZ = 20;
	localparam int T_WR_US = 5000;
	localparam int WR_CYCLES = T_WR_US * CLK_MHZ;
	localparam int WIPER_W = 6;
	localparam int NUM_POTS = 2;
	localparam int NUM_STORED = 4;
	// device type prefix, value arbitrary
	localparam logic [3:0] DEV_TYPE = 4'h6;
	localparam logic [5:0] NV_INIT = 6'h20;
	localparam int INS_OP_LSB = 4;
	localparam int INS_REG_LSB = 2;
	localparam int INS_POT_LSB = 0;
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'ha;
	localparam logic [3:0] OP_RD_STORED = 4'hb;
	localparam logic [3:0] OP_WR_STORED = 4'hc;
	localparam logic [3:0] OP_LOAD_WIPER = 4'hd;
	localparam logic [3:0] OP_SAVE_WIPER = 4'he;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_INSTR = 8'h04,
		ST_DATA = 8'h08,
		ST_ACK = 8'h10,
		ST_SEND = 8'h20,
		ST_RACK = 8'h40,
		ST_STEP = 8'h80
	} dwr_state_e;
	typedef enum logic [2:0] {
		SRC_ADDR = 3'h1,
		SRC_INSTR = 3'h2,
		SRC_DATA = 3'h4
	} dwr_src_e;
endpackage

// *** dwr_tap_decode.sv ***
// dwr_tap_decode: registered one-hot tap select for one pot.
// assumes pos_i comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dwr_tap_decode #(
	parameter int W = 6
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [W-1:0] pos_i,
	output logic [(2**W)-1:0] tap_o
);
	wire [(2**W)-1:0] next_tap = {{((2**W)-1){1'b0}}, 1'b1} << pos_i;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			tap_o <= {{((2**W)-1){1'b0}}, 1'b1};
		else if (ce_i)
			tap_o <= next_tap;
	end
endmodule // dwr_tap_decode
`default_nettype wire

// *** dwr_wiper_ctrl.sv ***
// dwr_wiper_ctrl: two-wire slave, wiper and stored-setting registers, programming timer.
// assumes scl, sda, straps and write guard are asynchronous pins; sda wired-and outside.
`timescale 1ns/1ps
`default_nettype none
module dwr_wiper_ctrl #(
	parameter int WR_CYCLES = dwr_pkg::WR_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [3:0] addr_strap_i,
	input wire logic wguard_n_i,
	output logic busy_o,
	output logic [63:0] tap0_o,
	output logic [63:0] tap1_o
);
	import dwr_pkg::*;
	localparam int CNT_W = $clog2(WR_CYCLES + 1);

	if (WR_CYCLES < 1) begin : g_bad_cycles
		$error("WR_CYCLES must be at least one");
	end

	logic [2:0] scl_q, sda_q;
	logic [3:0] strap_q0, strap_q1;
	logic [1:0] wg_q;
	dwr_state_e state;
	dwr_src_e src;
	logic [3:0] bitcnt;
	logic [7:0] shreg, instr, txreg;
	logic mack, pend;
	logic [2:0] pend_idx;
	logic [5:0] pend_val;
	logic [CNT_W-1:0] prog_cnt;
	logic [WIPER_W-1:0] wiper [NUM_POTS];
	logic [WIPER_W-1:0] nv [NUM_POTS*NUM_STORED] = '{default: NV_INIT};

	// all pins pass two flops; edge logic only looks at the second and third
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			strap_q0 <= 4'h0;
			strap_q1 <= 4'h0;
			wg_q <= 2'h3;
		end else if (ce_i) begin
			scl_q <= {scl_q[1:0], scl_i};
			sda_q <= {sda_q[1:0], sda_i};
			strap_q0 <= addr_strap_i;
			strap_q1 <= strap_q0;
			wg_q <= {wg_q[0], wguard_n_i};
		end
	end

	wire scl_s = scl_q[1];
	wire scl_d = scl_q[2];
	wire sda_s = sda_q[1];
	wire sda_d = sda_q[2];
	wire rise = scl_s & ~scl_d;
	wire fall = ~scl_s & scl_d;
	wire start = scl_s & scl_d & sda_d & ~sda_s;
	wire stop = scl_s & scl_d & ~sda_d & sda_s;
	// floating guard pin is pulled high on the board
	wire guard_ok = wg_q[1];
	wire shifting = (state == ST_ADDR) | (state == ST_INSTR) | (state == ST_DATA);
	wire byte_done = fall & shifting & (bitcnt == 4'h8);

	wire [3:0] op = instr[INS_OP_LSB +: 4];
	wire pot = instr[INS_POT_LSB];
	wire [2:0] nv_idx = {instr[INS_POT_LSB], instr[INS_REG_LSB +: 2]};
	wire [3:0] in_op = shreg[INS_OP_LSB +: 4];
	wire op_valid = (in_op == OP_STEP) | (in_op == OP_RD_WIPER) | (in_op == OP_WR_WIPER)
		| (in_op == OP_RD_STORED) | (in_op == OP_WR_STORED) | (in_op == OP_LOAD_WIPER)
		| (in_op == OP_SAVE_WIPER);
	wire addr_hit = (shreg == {DEV_TYPE, strap_q1}) & ~busy_o;
	wire nv_blocked = (op == OP_WR_STORED) & ~guard_ok;
	wire next_ack = (state == ST_ADDR) ? addr_hit :
		(state == ST_INSTR) ? op_valid : ~nv_blocked;
	wire [7:0] rd_val = (op == OP_RD_WIPER) ? {2'h0, wiper[pot]} : {2'h0, nv[nv_idx]};
	wire is_read = (op == OP_RD_WIPER) | (op == OP_RD_STORED);
	wire ack_end = fall & (state == ST_ACK);
	wire wr_wiper_fire = byte_done & (state == ST_DATA) & (op == OP_WR_WIPER);
	wire load_fire = ack_end & (src == SRC_INSTR) & (op == OP_LOAD_WIPER);
	wire step_fire = rise & (state == ST_STEP);
	wire prog_done = busy_o & (prog_cnt == '0);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			src <= SRC_ADDR;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			instr <= 8'h00;
			txreg <= 8'h00;
			mack <= 1'b0;
			pend <= 1'b0;
			pend_idx <= 3'h0;
			pend_val <= 6'h00;
			prog_cnt <= '0;
			busy_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (ce_i) begin
			if (prog_done)
				busy_o <= 1'b0;
			else if (busy_o)
				prog_cnt <= prog_cnt - 1'b1;
			if (start) begin
				state <= ST_ADDR;
				bitcnt <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (stop) begin
				state <= ST_IDLE;
				sda_oe_o <= 1'b0;
				pend <= 1'b0;
				// guard dropping before stop still cancels the programming
				if (pend && guard_ok && !busy_o) begin
					busy_o <= 1'b1;
					prog_cnt <= CNT_W'(WR_CYCLES - 1);
				end
			end else if (rise) begin
				if (shifting) begin
					shreg <= {shreg[6:0], sda_s};
					bitcnt <= bitcnt + 4'h1;
				end else if (state == ST_RACK) begin
					mack <= ~sda_s;
				end
			end else if (byte_done) begin
				sda_oe_o <= next_ack;
				state <= next_ack ? ST_ACK : ST_IDLE;
				bitcnt <= 4'h0;
				src <= (state == ST_ADDR) ? SRC_ADDR : (state == ST_INSTR) ? SRC_INSTR : SRC_DATA;
				if (state == ST_INSTR)
					instr <= shreg;
				if ((state == ST_DATA) && (op == OP_WR_STORED) && next_ack) begin
					pend <= 1'b1;
					pend_idx <= nv_idx;
					pend_val <= shreg[5:0];
				end
			end else if (fall) begin
				unique case (state)
				ST_ACK: begin
					sda_oe_o <= 1'b0;
					if (src == SRC_ADDR) begin
						state <= ST_INSTR;
					end else if (src == SRC_INSTR && is_read) begin
						state <= ST_SEND;
						txreg <= rd_val;
						sda_oe_o <= ~rd_val[7];
						bitcnt <= 4'h1;
					end else if (src == SRC_INSTR && op == OP_STEP) begin
						state <= ST_STEP;
					end else if (src == SRC_INSTR
						&& (op == OP_WR_WIPER || op == OP_WR_STORED)) begin
						state <= ST_DATA;
					end else begin
						state <= ST_IDLE;
						if (src == SRC_INSTR && op == OP_SAVE_WIPER) begin
							pend <= 1'b1;
							pend_idx <= nv_idx;
							pend_val <= wiper[pot];
						end
					end
				end
				ST_SEND: begin
					if (bitcnt == 4'h8) begin
						sda_oe_o <= 1'b0;
						state <= ST_RACK;
					end else begin
						sda_oe_o <= ~txreg[6];
						txreg <= {txreg[6:0], 1'b0};
						bitcnt <= bitcnt + 4'h1;
					end
				end
				ST_RACK: begin
					// master nack ends the read and waits for stop
					if (mack) begin
						state <= ST_SEND;
						txreg <= rd_val;
						sda_oe_o <= ~rd_val[7];
						bitcnt <= 4'h1;
					end else begin
						state <= ST_IDLE;
					end
				end
				default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wiper[0] <= nv[0];
			wiper[1] <= nv[NUM_STORED];
		end else if (ce_i) begin
			if (wr_wiper_fire)
				wiper[pot] <= shreg[5:0];
			else if (load_fire)
				wiper[pot] <= nv[nv_idx];
			else if (step_fire && sda_s && wiper[pot] != 6'h3f)
				wiper[pot] <= wiper[pot] + 6'h01;
			else if (step_fire && !sda_s && wiper[pot] != 6'h00)
				wiper[pot] <= wiper[pot] - 6'h01;
			if (prog_done)
				nv[pend_idx] <= pend_val;
		end
	end

	dwr_tap_decode #(.W(WIPER_W)) u_tap0 (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.pos_i(wiper[0]),
		.tap_o(tap0_o)
	);
	dwr_tap_decode #(.W(WIPER_W)) u_tap1 (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.pos_i(wiper[1]),
		.tap_o(tap1_o)
	);

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	a_drive_only_ack: assert property (sda_oe_o |-> state inside {ST_ACK, ST_SEND})
		else $error("data line driven outside ack or send");
	a_busy_addr_nack: assert property (busy_o && byte_done && state == ST_ADDR && ce_i
		|=> !sda_oe_o && state == ST_IDLE)
		else $error("address acked while programming");
	a_guard_data_nack: assert property (byte_done && state == ST_DATA && nv_blocked && ce_i
		|=> !sda_oe_o && !pend)
		else $error("guarded stored write was acked");
	a_guard_no_prog: assert property (stop && !guard_ok && !busy_o && ce_i |=> !busy_o)
		else $error("programming started with guard low");
	a_addr_strap: assert property (byte_done && state == ST_ADDR && ce_i && next_ack
		|=> sda_oe_o && $past(shreg[3:0]) == strap_q1)
		else $error("address acked without strap match");
	a_tap_onehot: assert property ($onehot(tap0_o) && $onehot(tap1_o))
		else $error("tap select not one-hot");
	// taps show bit0 during reset, so the first edge after release is not compared
	a_tap_follows: assert property (ce_i && $past(ce_i) && !$past(reset_i)
		|-> tap0_o == (64'h1 << $past(wiper[0])))
		else $error("tap does not follow wiper");
	a_powerup_load: assert property ($past(reset_i) |-> wiper[1] == nv[NUM_STORED])
		else $error("wiper not loaded from first stored setting");
	a_step_top: assert property (step_fire && sda_s && ce_i && wiper[pot] == 6'h3f
		|=> wiper[$past(pot)] == 6'h3f)
		else $error("step up passed the top tap");
	a_prog_len: assert property ($rose(busy_o) |-> busy_o [*8])
		else $error("programming cycle ended too early");
	a_freeze: assert property (!ce_i |=> $stable(state) && $stable(sda_oe_o))
		else $error("state moved with clock enable low");

	c_read: cover property (state == ST_RACK ##[1:200] state == ST_SEND);
	c_prog: cover property (prog_done);
	c_step: cover property (step_fire);
endmodule // dwr_wiper_ctrl
`default_nettype wire

// *** tb_top.sv ***
// tb_top: scenario bench for dwr_wiper_ctrl.
// assumes dwr_bus_master drives the bus; pull-up on sda.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dwr_pkg::*;
	localparam int WRC = 400;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wg_n = 1'b1;
	logic ce = 1'b1;
	logic [3:0] strap = 4'h9;
	logic [7:0] q;
	logic [2:0] ak;
	wire scl, m_low, oe, sda_v, busy, sda;
	wire [63:0] tap0, tap1;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	assign sda = (oe | m_low) ? 1'b0 : 1'b1;
	dwr_bus_master i_dwr_bus_master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
	dwr_wiper_ctrl #(.WR_CYCLES(WRC)) i_dwr_wiper_ctrl (.clk_sys_i(clk), .reset_i(rst),
		.ce_i(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_v), .sda_oe_o(oe),
		.addr_strap_i(strap), .wguard_n_i(wg_n), .busy_o(busy), .tap0_o(tap0), .tap1_o(tap1));
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// start, address, instruction, data or read byte, stop
	task automatic xfer(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] d,
		input logic rd);
		i_dwr_bus_master.start();
		i_dwr_bus_master.byte_x(a, 1'b0, q, ak[2]);
		i_dwr_bus_master.byte_x(ins, 1'b0, q, ak[1]);
		i_dwr_bus_master.byte_x(rd ? 8'hff : d, 1'b0, q, ak[0]);
		i_dwr_bus_master.stop();
	endtask
	task automatic wait_idle();
		i_dwr_bus_master.wt(3);
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
			i_dwr_bus_master.wt(1);
		end
		chk(busy, 1'b0);
	endtask
	task automatic t_reset();
		chk(tap0, 64'h1 << NV_INIT);
		chk(tap1, 64'h1 << NV_INIT);
		chk(sda_v, 1'b0);
		$display("t_reset done");
	endtask
	task automatic t_wiper();
		logic [5:0] v[3] = '{6'h00, 6'h3f, 6'h05};
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 3; k++) begin
				xfer({DEV_TYPE, strap}, {OP_WR_WIPER, 2'b00, 2'(p)}, {2'b00, v[k]}, 1'b0);
				chk(ak, 3'b111);
				chk(p ? tap1 : tap0, 64'h1 << v[k]);
				xfer({DEV_TYPE, strap}, {OP_RD_WIPER, 2'b00, 2'(p)}, 8'h00, 1'b1);
				chk(q, {2'b00, v[k]});
			end
		end
		$display("t_wiper done");
	endtask
	task automatic t_addr();
		xfer({DEV_TYPE, strap ^ 4'h1}, {OP_WR_WIPER, 4'h0}, 8'h01, 1'b0);
		chk(ak, 3'b000);
		xfer({~DEV_TYPE, strap}, {OP_WR_WIPER, 4'h0}, 8'h01, 1'b0);
		chk(ak, 3'b000);
		chk(tap0, 64'h1 << 5);
		// move the straps: old address must now be refused, new one served
		strap <= 4'h6;
		i_dwr_bus_master.wt(3);
		xfer({DEV_TYPE, 4'h9}, {OP_WR_WIPER, 4'h0}, 8'h01, 1'b0);
		chk(ak, 3'b000);
		xfer({DEV_TYPE, 4'h6}, {OP_WR_WIPER, 4'h0}, 8'h0c, 1'b0);
		chk(ak, 3'b111);
		chk(tap0, 64'h1 << 12);
		strap <= 4'h9;
		i_dwr_bus_master.wt(3);
		$display("t_addr done");
	endtask
	task automatic t_stored();
		xfer({DEV_TYPE, strap}, {OP_WR_STORED, 2'd2, 2'd0}, 8'h11, 1'b0);
		chk(ak, 3'b111);
		i_dwr_bus_master.wt(3);
		chk(busy, 1'b1);
		xfer({DEV_TYPE, strap}, {OP_RD_WIPER, 4'h0}, 8'h00, 1'b1);
		chk(ak[2], 1'b0);
		wait_idle();
		xfer({DEV_TYPE, strap}, {OP_RD_STORED, 2'd2, 2'd0}, 8'h00, 1'b1);
		chk(q, 8'h11);
		xfer({DEV_TYPE, strap}, {OP_LOAD_WIPER, 2'd2, 2'd0}, 8'h00, 1'b0);
		chk(tap0, 64'h1 << 17);
		xfer({DEV_TYPE, strap}, {OP_SAVE_WIPER, 2'd3, 2'd1}, 8'h00, 1'b0);
		wait_idle();
		xfer({DEV_TYPE, strap}, {OP_RD_STORED, 2'd3, 2'd1}, 8'h00, 1'b1);
		chk(q, 8'h05);
		$display("t_stored done");
	endtask
	task automatic t_guard();
		wg_n <= 1'b0;
		xfer({DEV_TYPE, strap}, {OP_WR_STORED, 2'd1, 2'd1}, 8'h2a, 1'b0);
		chk(ak, 3'b110);
		i_dwr_bus_master.wt(3);
		chk(busy, 1'b0);
		xfer({DEV_TYPE, strap}, {OP_WR_WIPER, 2'd0, 2'd1}, 8'h07, 1'b0);
		chk(tap1, 64'h1 << 7);
		wg_n <= 1'b1;
		xfer({DEV_TYPE, strap}, {OP_RD_STORED, 2'd1, 2'd1}, 8'h00, 1'b1);
		chk(q, {2'b00, NV_INIT});
		$display("t_guard done");
	endtask
	// a whole transfer runs while enable is low and is ignored; the frozen synchronisers hold idle-high levels
	task automatic t_freeze();
		xfer({DEV_TYPE, strap}, {OP_WR_WIPER, 4'h0}, 8'h2b, 1'b0);
		chk(ak, 3'b111);
		chk(tap0, 64'h1 << 43);
		ce <= 1'b0;
		xfer({DEV_TYPE, strap}, {OP_WR_WIPER, 4'h0}, 8'h13, 1'b0);
		chk(ak, 3'b000);
		chk(tap0, 64'h1 << 43);
		ce <= 1'b1;
		i_dwr_bus_master.wt(3);
		xfer({DEV_TYPE, strap}, {OP_WR_WIPER, 4'h0}, 8'h13, 1'b0);
		chk(ak, 3'b111);
		chk(tap0, 64'h1 << 19);
		$display("t_freeze done");
	endtask
	task automatic t_step();
		logic r;
		xfer({DEV_TYPE, strap}, {OP_WR_WIPER, 4'h0}, 8'h3e, 1'b0);
		i_dwr_bus_master.start();
		i_dwr_bus_master.byte_x({DEV_TYPE, strap}, 1'b0, q, ak[2]);
		i_dwr_bus_master.byte_x({OP_STEP, 4'h0}, 1'b0, q, ak[1]);
		for (int i = 0; i < 6; i++) begin
			i_dwr_bus_master.bit_x(i < 3, r);
			i_dwr_bus_master.wt(4);
			chk(tap0, 64'h1 << (i < 3 ? 63 : 65 - i));
		end
		i_dwr_bus_master.stop();
		$display("t_step done");
	endtask
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ceiling well above the few thousand cycles the scenarios need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		i_dwr_bus_master.wt(5);
		t_reset();
		t_wiper();
		t_addr();
		t_stored();
		t_guard();
		t_freeze();
		t_step();
		test_done();
	end
endmodule // tb_top
`default_nettype wire
